//--- core/mcsi_pkg.sv
package mcsi_pkg;
    // Axis count: one request or flag word carries sixteen axes
    localparam int NAX = 16;
    localparam int AW  = 5;
    localparam int DW  = 16;

    // Register offsets (word index on the plain register port)
    localparam logic [4:0] OFF_CTRL     = 5'h00;
    localparam logic [4:0] OFF_DEC_TIME = 5'h01;
    localparam logic [4:0] OFF_EMG_TIME = 5'h02;
    localparam logic [4:0] OFF_BUSY     = 5'h03;
    localparam logic [4:0] OFF_DONE     = 5'h04;
    localparam logic [4:0] OFF_IRQ_STAT = 5'h05;
    localparam logic [4:0] OFF_IRQ_MASK = 5'h06;
    localparam logic [4:0] OFF_MON_SEL  = 5'h07;
    localparam logic [4:0] OFF_MON_BASE = 5'h08;  // 0x08..0x11, low word then high word
    localparam logic [4:0] OFF_MON_LAST = 5'h11;

    // Control field: reaction to the host entering program mode
    localparam int CTRL_REACT_LSB = 0;
    localparam logic [1:0] REACT_CONT = 2'h0;
    localparam logic [1:0] REACT_DEC  = 2'h1;
    localparam logic [1:0] REACT_IMM  = 2'h2;

    // Reset values
    localparam logic [15:0] RST_DEC_TIME = 16'h0064;
    localparam logic [15:0] RST_EMG_TIME = 16'h000a;
    localparam logic [4:0]  RST_IRQ_MASK = 5'h00;
    localparam logic [3:0]  RST_MON_SEL  = 4'h0;

    // Interrupt status bit positions
    localparam int EV_START  = 0;
    localparam int EV_IGNORE = 1;
    localparam int EV_STOP   = 2;
    localparam int EV_DONE   = 3;
    localparam int EV_MODE   = 4;
    localparam int NEV       = 5;

    // Operation kinds
    localparam logic [1:0] KIND_POS  = 2'h0;
    localparam logic [1:0] KIND_SYNC = 2'h1;
    localparam logic [1:0] KIND_JOG  = 2'h2;
    localparam logic [1:0] KIND_HOME = 2'h3;

    typedef enum logic [3:0] {
        AX_IDLE  = 4'h1,
        AX_RUN   = 4'h2,
        AX_DECEL = 4'h4,
        AX_EMG   = 4'h8
    } mcsi_ax_t;

    // Host request and stop bits, one bit per axis except the single sys_stop and program_mode bits
    typedef struct packed {
        logic [NAX-1:0] pos;
        logic [NAX-1:0] sync;
        logic [NAX-1:0] jog;
        logic [NAX-1:0] home;
        logic           sys_stop;
        logic [NAX-1:0] limit_stop;
        logic [NAX-1:0] err_stop;
        logic [NAX-1:0] emg_stop;
        logic [NAX-1:0] dec_stop;
        logic           program_mode;
    } mcsi_req_t;

    // Two-word monitor values of the selected axis
    typedef struct packed {
        logic [31:0] speed;
        logic [31:0] deviation;
        logic [31:0] amp_pos;
        logic [31:0] conv_pos;
        logic [31:0] advance;
    } mcsi_mon_t;

    // Register port request
    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic          wr;
        logic          rd;
    } mcsi_bus_t;
endpackage : mcsi_pkg

//--- core/mcsi_top.sv
`timescale 1ns/1ps
module mcsi_top (
    input  wire logic                     CLK_SYS,
    input  wire logic                     NRST,
    input  wire mcsi_pkg::mcsi_req_t      REQ,
    input  wire logic [mcsi_pkg::NAX-1:0] AXIS_DONE,
    input  wire mcsi_pkg::mcsi_mon_t      MON,
    input  wire mcsi_pkg::mcsi_bus_t      BUS,
    output logic [mcsi_pkg::DW-1:0]       RDATA,
    output logic [mcsi_pkg::NAX-1:0]      BUSY,
    output logic [mcsi_pkg::NAX-1:0]      DONE,
    output logic [mcsi_pkg::NAX-1:0]      DECEL,
    output logic [mcsi_pkg::NAX-1:0]      EMG,
    output logic [2*mcsi_pkg::NAX-1:0]    KIND,
    output logic [3:0]                    MON_AXIS,
    output logic                          IRQ
);

    typedef struct packed {
        mcsi_pkg::mcsi_req_t                      rq1;
        mcsi_pkg::mcsi_req_t                      rq2;
        mcsi_pkg::mcsi_req_t                      rq3;
        mcsi_pkg::mcsi_ax_t [mcsi_pkg::NAX-1:0]   st;
        logic [mcsi_pkg::NAX-1:0][15:0]           tmr;
        logic [mcsi_pkg::NAX-1:0][1:0]            kind;
        logic [mcsi_pkg::NAX-1:0]                 busy;
        logic [mcsi_pkg::NAX-1:0]                 done;
        logic [1:0]                               react;
        logic [15:0]                              dec_time;
        logic [15:0]                              emg_time;
        logic [mcsi_pkg::NEV-1:0]                 stat;
        logic [mcsi_pkg::NEV-1:0]                 mask;
        logic [3:0]                               mon_sel;
        logic [mcsi_pkg::DW-1:0]                  rdata;
        logic                                     irq;
    } mcsi_state_t;

    mcsi_state_t s_q;
    mcsi_state_t s_d;

    // Pick the half-word of a monitor value; halves are read live, never snapshot
    function automatic logic [15:0] mcsi_mon_half(input mcsi_pkg::mcsi_mon_t m, input logic [4:0] a);
        logic [4:0]  idx;
        logic [31:0] w;
        idx = a - mcsi_pkg::OFF_MON_BASE;
        unique case (idx[3:1])
            3'h0:    w = m.speed;
            3'h1:    w = m.deviation;
            3'h2:    w = m.amp_pos;
            3'h3:    w = m.conv_pos;
            3'h4:    w = m.advance;
            default: w = 32'h00000000;
        endcase
        return idx[0] ? w[31:16] : w[15:0];
    endfunction : mcsi_mon_half

    // Rising edge of a synchronised request word against its previous stage
    function automatic logic [mcsi_pkg::NAX-1:0] mcsi_rise(input logic [mcsi_pkg::NAX-1:0] cur,
                                                           input logic [mcsi_pkg::NAX-1:0] prev);
        return cur & ~prev;
    endfunction : mcsi_rise

    // Next-state logic
    always_comb begin
        logic [mcsi_pkg::NAX-1:0] e_pos, e_sync, e_jog, e_home, any_start, stop_hard, stop_soft;
        logic [mcsi_pkg::NEV-1:0] ev;
        logic [mcsi_pkg::NEV-1:0] clr;
        logic                     mode_edge;
        s_d = s_q;
        ev = '0;
        clr = '0;
        // Two-flop synchronisers plus a third stage for edge detection
        s_d.rq1 = REQ;
        s_d.rq2 = s_q.rq1;
        s_d.rq3 = s_q.rq2;
        e_pos  = mcsi_rise(s_q.rq2.pos, s_q.rq3.pos);
        e_sync = mcsi_rise(s_q.rq2.sync, s_q.rq3.sync);
        e_jog  = mcsi_rise(s_q.rq2.jog, s_q.rq3.jog);
        e_home = mcsi_rise(s_q.rq2.home, s_q.rq3.home);
        any_start = e_pos | e_sync | e_jog | e_home;
        stop_hard = {mcsi_pkg::NAX{s_q.rq2.sys_stop}} | s_q.rq2.limit_stop
                  | s_q.rq2.err_stop | s_q.rq2.emg_stop;
        stop_soft = s_q.rq2.dec_stop;
        mode_edge = s_q.rq2.program_mode & ~s_q.rq3.program_mode;
        if (mode_edge) begin
            ev[mcsi_pkg::EV_MODE] = 1'b1;
        end
        // Each axis arbitrates alone; no term couples two axes
        for (int a = 0; a < mcsi_pkg::NAX; a++) begin
            unique case (s_q.st[a])
                mcsi_pkg::AX_IDLE: begin
                    // A held stop also blocks a start; stops win
                    if (any_start[a] && !(stop_hard[a] || stop_soft[a])) begin
                        s_d.st[a] = mcsi_pkg::AX_RUN;
                        s_d.done[a] = 1'b0;
                        ev[mcsi_pkg::EV_START] = 1'b1;
                        if (e_pos[a]) begin
                            s_d.kind[a] = mcsi_pkg::KIND_POS;
                        end else if (e_sync[a]) begin
                            s_d.kind[a] = mcsi_pkg::KIND_SYNC;
                        end else if (e_jog[a]) begin
                            s_d.kind[a] = mcsi_pkg::KIND_JOG;
                        end else begin
                            s_d.kind[a] = mcsi_pkg::KIND_HOME;
                        end
                    end else if (any_start[a]) begin
                        ev[mcsi_pkg::EV_IGNORE] = 1'b1;
                    end
                end
                mcsi_pkg::AX_RUN: begin
                    if (any_start[a]) begin
                        ev[mcsi_pkg::EV_IGNORE] = 1'b1;
                    end
                    if (stop_hard[a] || (mode_edge && s_q.react == mcsi_pkg::REACT_IMM)) begin
                        s_d.st[a] = mcsi_pkg::AX_EMG;
                        s_d.tmr[a] = s_q.emg_time;
                        ev[mcsi_pkg::EV_STOP] = 1'b1;
                    end else if (stop_soft[a] || (mode_edge && s_q.react == mcsi_pkg::REACT_DEC)) begin
                        s_d.st[a] = mcsi_pkg::AX_DECEL;
                        s_d.tmr[a] = s_q.dec_time;
                        ev[mcsi_pkg::EV_STOP] = 1'b1;
                    end else if (AXIS_DONE[a]) begin
                        s_d.st[a] = mcsi_pkg::AX_IDLE;
                        s_d.done[a] = 1'b1;
                        ev[mcsi_pkg::EV_DONE] = 1'b1;
                    end
                end
                mcsi_pkg::AX_DECEL: begin
                    if (any_start[a]) begin
                        ev[mcsi_pkg::EV_IGNORE] = 1'b1;
                    end
                    // A harder stop cuts a running deceleration short
                    if (stop_hard[a] || (mode_edge && s_q.react == mcsi_pkg::REACT_IMM)) begin
                        s_d.st[a] = mcsi_pkg::AX_EMG;
                        s_d.tmr[a] = s_q.emg_time;
                        ev[mcsi_pkg::EV_STOP] = 1'b1;
                    end else if (s_q.tmr[a] <= 16'h0001) begin
                        s_d.st[a] = mcsi_pkg::AX_IDLE;
                        s_d.tmr[a] = 16'h0000;
                        s_d.done[a] = 1'b1;
                        ev[mcsi_pkg::EV_DONE] = 1'b1;
                    end else begin
                        s_d.tmr[a] = s_q.tmr[a] - 16'h0001;
                    end
                end
                mcsi_pkg::AX_EMG: begin
                    if (any_start[a]) begin
                        ev[mcsi_pkg::EV_IGNORE] = 1'b1;
                    end
                    if (s_q.tmr[a] <= 16'h0001) begin
                        s_d.st[a] = mcsi_pkg::AX_IDLE;
                        s_d.tmr[a] = 16'h0000;
                        s_d.done[a] = 1'b1;
                        ev[mcsi_pkg::EV_DONE] = 1'b1;
                    end else begin
                        s_d.tmr[a] = s_q.tmr[a] - 16'h0001;
                    end
                end
                default: begin
                    s_d.st[a] = mcsi_pkg::AX_IDLE;
                    s_d.tmr[a] = 16'h0000;
                end
            endcase
            s_d.busy[a] = (s_d.st[a] != mcsi_pkg::AX_IDLE);
        end
        // Register writes
        if (BUS.wr) begin
            unique case (BUS.addr)
                mcsi_pkg::OFF_CTRL:     s_d.react = BUS.wdata[mcsi_pkg::CTRL_REACT_LSB +: 2];
                mcsi_pkg::OFF_DEC_TIME: s_d.dec_time = BUS.wdata;
                mcsi_pkg::OFF_EMG_TIME: s_d.emg_time = BUS.wdata;
                mcsi_pkg::OFF_IRQ_STAT: clr = BUS.wdata[mcsi_pkg::NEV-1:0];
                mcsi_pkg::OFF_IRQ_MASK: s_d.mask = BUS.wdata[mcsi_pkg::NEV-1:0];
                mcsi_pkg::OFF_MON_SEL:  s_d.mon_sel = BUS.wdata[3:0];
                default: ;
            endcase
        end
        // New events beat a clear in the same cycle
        s_d.stat = (s_q.stat & ~clr) | ev;
        s_d.irq = |(s_d.stat & s_d.mask);
        // Read data stands only in the cycle after the strobe
        s_d.rdata = 16'h0000;
        if (BUS.rd) begin
            if (BUS.addr >= mcsi_pkg::OFF_MON_BASE && BUS.addr <= mcsi_pkg::OFF_MON_LAST) begin
                s_d.rdata = mcsi_mon_half(MON, BUS.addr);
            end else begin
                unique case (BUS.addr)
                    mcsi_pkg::OFF_CTRL:     s_d.rdata = {14'h0000, s_q.react};
                    mcsi_pkg::OFF_DEC_TIME: s_d.rdata = s_q.dec_time;
                    mcsi_pkg::OFF_EMG_TIME: s_d.rdata = s_q.emg_time;
                    mcsi_pkg::OFF_BUSY:     s_d.rdata = s_q.busy;
                    mcsi_pkg::OFF_DONE:     s_d.rdata = s_q.done;
                    mcsi_pkg::OFF_IRQ_STAT: s_d.rdata = {11'h000, s_q.stat};
                    mcsi_pkg::OFF_IRQ_MASK: s_d.rdata = {11'h000, s_q.mask};
                    mcsi_pkg::OFF_MON_SEL:  s_d.rdata = {12'h000, s_q.mon_sel};
                    default:                s_d.rdata = 16'h0000;
                endcase
            end
        end
    end

    // State register; reset puts every axis idle
    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            s_q <= '0;
            for (int a = 0; a < mcsi_pkg::NAX; a++) begin
                s_q.st[a] <= mcsi_pkg::AX_IDLE;
            end
            s_q.react <= mcsi_pkg::REACT_DEC;
            s_q.dec_time <= mcsi_pkg::RST_DEC_TIME;
            s_q.emg_time <= mcsi_pkg::RST_EMG_TIME;
            s_q.mask <= mcsi_pkg::RST_IRQ_MASK;
            s_q.mon_sel <= mcsi_pkg::RST_MON_SEL;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    always_comb begin
        RDATA = s_q.rdata;
        BUSY = s_q.busy;
        DONE = s_q.done;
        KIND = s_q.kind;
        MON_AXIS = s_q.mon_sel;
        IRQ = s_q.irq;
        for (int a = 0; a < mcsi_pkg::NAX; a++) begin
            DECEL[a] = (s_q.st[a] == mcsi_pkg::AX_DECEL);
            EMG[a] = (s_q.st[a] == mcsi_pkg::AX_EMG);
        end
    end

    // Assertions, watched on axis 0 and 1
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);

    logic [3:0] stop0;
    logic       mode_e;
    assign stop0 = {s_q.rq2.sys_stop, s_q.rq2.limit_stop[0] | s_q.rq2.err_stop[0],
                    s_q.rq2.emg_stop[0], s_q.rq2.dec_stop[0]};
    assign mode_e = s_q.rq2.program_mode & ~s_q.rq3.program_mode;

    sequence seq_pos_edge0;
        s_q.rq2.pos[0] && !s_q.rq3.pos[0] && stop0 == 4'h0;
    endsequence
    sequence seq_run0;
        s_q.st[0] == mcsi_pkg::AX_RUN;
    endsequence
    sequence seq_quiet_run0;
        seq_run0 ##0 (stop0 == 4'h0 && !AXIS_DONE[0]);
    endsequence
    // Axis 1 carries the interlock case; axis 0 carries stops and timed endings
    sequence seq_jog_edge1;
        s_q.st[1] == mcsi_pkg::AX_RUN && s_q.rq2.jog[1] && !s_q.rq3.jog[1];
    endsequence
    sequence seq_decel_last0;
        DECEL[0] && s_q.tmr[0] == 16'h0001 && stop0[3:1] == 3'h0
        && !(mode_e && s_q.react == mcsi_pkg::REACT_IMM);
    endsequence

    a_start_lock_kind: assert property (
        seq_jog_edge1 |=> $stable(KIND[3:2]))
        else $error("Start during operation changed the operation kind");
    a_ignore_flagged: assert property (
        seq_jog_edge1 |=> s_q.stat[mcsi_pkg::EV_IGNORE])
        else $error("Start during operation was not flagged as ignored");
    a_busy_follows_run: assert property (
        seq_pos_edge0 ##0 (s_q.st[0] == mcsi_pkg::AX_IDLE) |=> BUSY[0] ##1 (BUSY[0] || DONE[0]))
        else $error("Busy did not rise with an accepted start");
    a_stop_priority: assert property (
        seq_run0 ##0 (stop0 != 4'h0) |=> (DECEL[0] || EMG[0]) && BUSY[0])
        else $error("Stop request did not preempt a running axis");
    a_react_default: assert property (@(posedge CLK_SYS) disable iff (1'b0)
        !NRST |=> s_q.react == mcsi_pkg::REACT_DEC)
        else $error("Program mode reaction does not reset to deceleration");
    a_mode_continue: assert property (
        seq_quiet_run0 ##0 (mode_e && s_q.react == mcsi_pkg::REACT_CONT) |=> seq_run0)
        else $error("Continue reaction disturbed a running axis");
    a_mode_decel: assert property (
        seq_quiet_run0 ##0 (mode_e && s_q.react == mcsi_pkg::REACT_DEC)
        |=> DECEL[0] && s_q.tmr[0] == $past(s_q.dec_time))
        else $error("Deceleration reaction did not load the deceleration time");
    a_mode_immediate: assert property (
        seq_quiet_run0 ##0 (mode_e && s_q.react == mcsi_pkg::REACT_IMM)
        |=> EMG[0] && s_q.tmr[0] == $past(s_q.emg_time))
        else $error("Immediate reaction did not load the emergency time");
    a_emg_ends_timed: assert property (
        EMG[0] && s_q.tmr[0] == 16'h0001 |=> !BUSY[0] && DONE[0])
        else $error("Emergency stop did not end when its time ran out");
    a_monitor_live: assert property (
        BUS.rd && BUS.addr == mcsi_pkg::OFF_MON_BASE |=> RDATA == $past(MON.speed[15:0]))
        else $error("Speed low word not returned live");
    a_level_no_start: assert property (
        s_q.st[0] == mcsi_pkg::AX_IDLE && s_q.rq3.pos[0] && !s_q.rq2.sync[0] && !s_q.rq2.jog[0]
        && !s_q.rq2.home[0] |=> !BUSY[0])
        else $error("Held positioning request started the axis");
    a_axis_indep: assert property (
        seq_pos_edge0 ##0 (s_q.st[0] == mcsi_pkg::AX_IDLE && BUSY[1]) |=> BUSY[0])
        else $error("Busy neighbour blocked a start on axis 0");

    // Busy and done around an accepted start
    a_busy_holds: assert property (
        seq_run0 ##0 !AXIS_DONE[0] |=> BUSY[0])
        else $error("Busy dropped while the operation was still running");
    a_done_cleared: assert property (
        seq_pos_edge0 ##0 (s_q.st[0] == mcsi_pkg::AX_IDLE) |=> !DONE[0])
        else $error("Accepted start left the done flag set");

    // Stop entry loads the matching time; a hard stop always wins over a soft one
    a_emg_hard_stop: assert property (
        seq_run0 ##0 (stop0[3:1] != 3'h0) |=> EMG[0] && s_q.tmr[0] == $past(s_q.emg_time))
        else $error("Hard stop did not load the emergency time");
    a_decel_soft_stop: assert property (
        seq_run0 ##0 (stop0 == 4'h1 && !(mode_e && s_q.react == mcsi_pkg::REACT_IMM))
        |=> DECEL[0] && s_q.tmr[0] == $past(s_q.dec_time))
        else $error("Deceleration stop did not load the deceleration time");
    a_decel_ends_timed: assert property (
        seq_decel_last0 |=> !BUSY[0] && DONE[0])
        else $error("Deceleration stop did not end when its time ran out");

    // Both halves of a monitor are live; the host copes with tearing
    a_monitor_high: assert property (
        BUS.rd && BUS.addr == mcsi_pkg::OFF_MON_BASE + 5'h01 |=> RDATA == $past(MON.speed[31:16]))
        else $error("Speed high word not returned live");
    a_monitor_last: assert property (
        BUS.rd && BUS.addr == mcsi_pkg::OFF_MON_LAST |=> RDATA == $past(MON.advance[31:16]))
        else $error("Advance high word not returned live");

endmodule : mcsi_top

//--- test/mcsi_host.sv
`timescale 1ns/1ps
// Host model: owns the register port, latches busy and reads two-word monitors
module mcsi_host (
    input  wire logic                     clk,
    output mcsi_pkg::mcsi_bus_t           bus,
    input  wire logic [mcsi_pkg::DW-1:0]  rdata,
    input  wire logic [mcsi_pkg::NAX-1:0] busy
);
    logic [mcsi_pkg::NAX-1:0] busy_status_word;
    logic [mcsi_pkg::NAX-1:0] busy_prev_q;
    logic                     scan_clr;
    initial begin
        bus = '0;
        busy_status_word = '0;
        busy_prev_q = '0;
        scan_clr = 1'b0;
    end
    // Sampled every cycle, so a pulse shorter than a scan is still caught
    always @(posedge clk) begin
        busy_prev_q <= busy;
        busy_status_word <= scan_clr ? busy : busy_status_word | busy | (busy & ~busy_prev_q);
        scan_clr <= 1'b0;
    end
    // Slow scan: takes the merged word and restarts it
    task scan(output logic [15:0] w);
        @(negedge clk);
        w = busy_status_word;
        scan_clr <= 1'b1;
        @(posedge clk);
    endtask : scan
    task wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask : rd
    // Halves are read apart, so two passes are compared and a third settles a tear
    task rd32(input logic [4:0] a, output logic [31:0] v);
        logic [15:0] l0, h0, l1, h1;
        rd(a, l0);
        rd(a + 5'h01, h0);
        rd(a, l1);
        rd(a + 5'h01, h1);
        v = {h1, l1};
        if ({h0, l0} !== v) begin
            rd(a, l1);
            rd(a + 5'h01, h1);
            v = {h1, l1};
        end
    endtask : rd32
endmodule : mcsi_host

//--- test/tb_mcsi_top.sv
`timescale 1ns/1ps
// Bench: starts per kind, interlock, stops, mode reaction, interrupts, monitors
module tb_mcsi_top;
    typedef struct packed { logic [1:0] kd; logic [3:0] ax; } mcsi_row_t;
    logic                clk;
    logic                nrst;
    mcsi_pkg::mcsi_req_t req;
    logic [15:0]         axis_done;
    mcsi_pkg::mcsi_mon_t mon;
    mcsi_pkg::mcsi_bus_t bus;
    logic [15:0]         rdata, busy, done, decel, emg, rv;
    logic [31:0]         kind, wv;
    logic [3:0]          mon_axis;
    logic                irq;
    int                  bad_count, total_checks;
    mcsi_row_t           rows [4] = '{'{2'h0, 4'h0}, '{2'h1, 4'h5}, '{2'h2, 4'ha}, '{2'h3, 4'hf}};

    mcsi_top u_mcsi_top (.CLK_SYS(clk), .NRST(nrst), .REQ(req), .AXIS_DONE(axis_done), .MON(mon), .BUS(bus),
        .RDATA(rdata), .BUSY(busy), .DONE(done), .DECEL(decel), .EMG(emg), .KIND(kind), .MON_AXIS(mon_axis),
        .IRQ(irq));
    mcsi_host u_mcsi_host (.clk(clk), .bus(bus), .rdata(rdata), .busy(busy));

    always #20 clk = ~clk;

    task wrap_up;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Bounded wait for busy (0), decel (1) or emergency (2) of one axis
    task wait_for(input int a, input logic lvl, input logic [1:0] w);
        int n;
        for (n = 0; n < 12; n++) begin
            @(posedge clk);
            #1;
            if ((w == 2'h0 ? busy[a] : w == 2'h1 ? decel[a] : emg[a]) === lvl) break;
        end
        if (n == 12) begin
            bad_count++;
            $display("ERROR %0t wait ran out", $time);
            wrap_up();
        end
    endtask : wait_for
    task start(input logic [1:0] k, input int a, input logic v);
        @(posedge clk);
        case (k)
            2'h0: req.pos[a] <= v;
            2'h1: req.sync[a] <= v;
            2'h2: req.jog[a] <= v;
            default: req.home[a] <= v;
        endcase
    endtask : start
    task stop(input int s, input logic v);
        @(posedge clk);
        case (s)
            0: req.sys_stop <= v;
            1: req.limit_stop[0] <= v;
            2: req.err_stop[0] <= v;
            3: req.emg_stop[0] <= v;
            default: req.dec_stop[0] <= v;
        endcase
    endtask : stop
    task pulse_done(input logic [15:0] m);
        @(posedge clk);
        axis_done <= m;
        @(posedge clk);
        axis_done <= 16'h0000;
    endtask : pulse_done

    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        req = '0;
        axis_done = '0;
        mon = {32'h1111_2222, 32'h3333_4444, 32'h5555_6666, 32'h7777_8888, 32'h9999_aaaa};
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        // Reset values, a read-only word and an unmapped word
        u_mcsi_host.rd(mcsi_pkg::OFF_CTRL, rv);
        chk(32'(rv & 16'h0003), 32'h1);
        u_mcsi_host.rd(mcsi_pkg::OFF_DEC_TIME, rv);
        chk(32'(rv), 32'(mcsi_pkg::RST_DEC_TIME));
        u_mcsi_host.wr(mcsi_pkg::OFF_BUSY, 16'hffff);
        u_mcsi_host.rd(mcsi_pkg::OFF_BUSY, rv);
        chk(32'(rv), 32'h0);
        u_mcsi_host.rd(5'h1f, rv);
        chk(32'(rv), 32'h0);
        // Short timers keep the stop states brief
        u_mcsi_host.wr(mcsi_pkg::OFF_DEC_TIME, 16'h0004);
        u_mcsi_host.wr(mcsi_pkg::OFF_EMG_TIME, 16'h0004);
        u_mcsi_host.wr(mcsi_pkg::OFF_IRQ_MASK, 16'h001f);
        u_mcsi_host.scan(rv);
        // Table rows: one start kind on one axis, then completion
        foreach (rows[i]) begin
            start(rows[i].kd, rows[i].ax, 1'b1);
            wait_for(rows[i].ax, 1'b1, 2'h0);
            chk(32'(kind[2*rows[i].ax +: 2]), 32'(rows[i].kd));
            chk(32'(done[rows[i].ax]), 32'h0);
            start(rows[i].kd, rows[i].ax, 1'b0);
            pulse_done(16'h0001 << rows[i].ax);
            wait_for(rows[i].ax, 1'b0, 2'h0);
            chk(32'(done[rows[i].ax]), 32'h1);
        end
        u_mcsi_host.scan(rv);
        chk(32'(rv), 32'h8421);
        // A second start on a busy axis is dropped while a neighbour still starts
        start(mcsi_pkg::KIND_POS, 1, 1'b1);
        wait_for(1, 1'b1, 2'h0);
        u_mcsi_host.wr(mcsi_pkg::OFF_IRQ_STAT, 16'h001f);
        start(mcsi_pkg::KIND_JOG, 1, 1'b1);
        start(mcsi_pkg::KIND_POS, 0, 1'b1);
        wait_for(0, 1'b1, 2'h0);
        chk(32'(kind[3:2]), 32'(mcsi_pkg::KIND_POS));
        u_mcsi_host.rd(mcsi_pkg::OFF_IRQ_STAT, rv);
        chk(32'({irq, rv[mcsi_pkg::EV_IGNORE]}), 32'h3);
        pulse_done(16'h0003);
        repeat (8) @(posedge clk);
        #1 chk(32'(busy[1:0]), 32'h0);
        @(posedge clk);
        req <= '0;
        u_mcsi_host.wr(mcsi_pkg::OFF_IRQ_MASK, 16'h0000);
        u_mcsi_host.wr(mcsi_pkg::OFF_IRQ_STAT, 16'h001f);
        // Every stop kind cuts a running operation short
        for (int s = 0; s < 5; s++) begin
            start(mcsi_pkg::KIND_JOG, 0, 1'b1);
            wait_for(0, 1'b1, 2'h0);
            stop(s, 1'b1);
            wait_for(0, 1'b1, s == 4 ? 2'h1 : 2'h2);
            wait_for(0, 1'b0, 2'h0);
            stop(s, 1'b0);
            start(mcsi_pkg::KIND_JOG, 0, 1'b0);
        end
        u_mcsi_host.rd(mcsi_pkg::OFF_IRQ_STAT, rv);
        chk(32'({irq, rv[mcsi_pkg::EV_STOP]}), 32'h1);
        u_mcsi_host.wr(mcsi_pkg::OFF_IRQ_STAT, 16'h001f);
        u_mcsi_host.rd(mcsi_pkg::OFF_IRQ_STAT, rv);
        chk(32'(rv), 32'h0);
        // Program mode reaction: continue, decelerate, immediate
        for (int r = 0; r < 3; r++) begin
            u_mcsi_host.wr(mcsi_pkg::OFF_CTRL, 16'(r));
            start(mcsi_pkg::KIND_HOME, 0, 1'b1);
            wait_for(0, 1'b1, 2'h0);
            @(posedge clk);
            req.program_mode <= 1'b1;
            if (r == 0) begin
                repeat (8) @(posedge clk);
                #1 chk(32'({busy[0], decel[0], emg[0]}), 32'h4);
                pulse_done(16'h0001);
            end else begin
                wait_for(0, 1'b1, 2'(r));
            end
            wait_for(0, 1'b0, 2'h0);
            @(posedge clk);
            req.program_mode <= 1'b0;
            req.home[0] <= 1'b0;
        end
        // Start, stop, end and mode entry events, no ignored start
        u_mcsi_host.rd(mcsi_pkg::OFF_IRQ_STAT, rv);
        chk(32'(rv), 32'h1d);
        // Two-word monitors, then one torn read
        u_mcsi_host.wr(mcsi_pkg::OFF_MON_SEL, 16'h0003);
        #1 chk(32'(mon_axis), 32'h3);
        for (int m = 0; m < 5; m++) begin
            u_mcsi_host.rd32(5'(mcsi_pkg::OFF_MON_BASE + 2*m), wv);
            chk(wv, mon[32*(4-m) +: 32]);
        end
        fork
            u_mcsi_host.rd32(mcsi_pkg::OFF_MON_BASE, wv);
            begin
                repeat (2) @(posedge clk);
                mon.speed <= 32'hcafe_0000;
            end
        join
        chk(wv, 32'hcafe_0000);
        wrap_up();
    end
endmodule : tb_mcsi_top
